// ===== hdl/cidr_config_regs.sv
// Clock input, reference and output divider configuration register bank
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] Reference source bit 0 picks crystal when 0, external clock when 1.
// [R2] I/O level bit sets control pins to 1.8 V when 0, 3.3 V when 1.
// [R3] Host at 3.3 V with 1.8 V core must select the 3.3 V level.
// [R4] Input enable bit 1 enables buffer; 0 disables and powers it down.
// [R5] Upper nibble format bits pick standard format at 0, pulsed CMOS at 1.
// [R6] Input n uses enable bit n and format bit n+4.
// [R7] Threshold bits 7:4 pick pulsed CMOS buffer at 0, LVCMOS at 1.
// [R8] Divider mode bit n makes divider n fractional at 0, integer at 1.
// [R9] Host must pulse soft reset after changing divider mode bits.
// [R10] Dividers that may go fractional should start with mode bit 0.
// [R11] Divider power bit 0 powers divider down; active dividers need 1.
// [R12] Routing bit n connects divider n clock to output driver muxes.
// [R13] Split fields keep the lower address in the least significant bits.
// [R14] A write updates every field of the addressed byte together.
module cidr_config_regs
  import cidr_pkg::*;
#(
  parameter int NUM_INPUTS = CIDR_NUM_INPUTS,
  parameter int NUM_DIVIDERS = CIDR_NUM_DIVIDERS
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  input wire logic soft_reset,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  output logic reference_source_external,
  output logic io_level_3v3,
  output logic [NUM_INPUTS-1:0] input_buffer_on,
  output logic [NUM_INPUTS-1:0] input_pulsed_cmos,
  output logic [NUM_INPUTS-1:0] cmos_threshold_lvcmos,
  output logic [NUM_INPUTS-1:0] input_to_detector_enable,
  output logic [11:0] input_hysteresis_select,
  output logic output_ceiling_enable,
  output logic [15:0] output_ceiling_value,
  output logic holdover_settle_detect_enable,
  output logic [15:0] holdover_settle_goal,
  output logic reference_multiplier_integer_mode,
  output logic [NUM_DIVIDERS-1:0] divider_half_add,
  output logic [NUM_DIVIDERS-1:0] divider_integer_mode,
  output logic [NUM_DIVIDERS-1:0] divider_power_on,
  output logic [NUM_DIVIDERS-1:0] divider_output_routing
);

  // Software visible register state
  logic limit_en_reg;
  logic settle_det_en_reg;
  logic [15:0] limit_reg;
  logic [15:0] settle_reg;
  logic ref_src_reg;
  logic io_level_reg;
  logic [NUM_INPUTS-1:0] in_en_reg;
  logic [NUM_INPUTS-1:0] in_fmt_reg;
  logic [NUM_INPUTS-1:0] in_det_reg;
  logic [11:0] hys_reg;
  logic [NUM_INPUTS-1:0] cmos_thr_reg;
  logic ref_mult_int_reg;
  logic [NUM_DIVIDERS-1:0] half_add_reg;
  logic [NUM_DIVIDERS-1:0] routing_reg;
  logic [NUM_DIVIDERS-1:0] int_mode_reg;
  logic [NUM_DIVIDERS-1:0] power_reg;

  // Divider mode actually applied to the datapath
  logic [NUM_DIVIDERS-1:0] int_mode_applied_next;

  logic [7:0] rdata_next;

  // Limit and settle enables share one byte; each process decodes its own bytes
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      limit_en_reg <= CIDR_LIMIT_EN_RST;
      settle_det_en_reg <= CIDR_SETTLE_DET_EN_RST;
    end
    else if (clk_en && reg_wr_en && (reg_addr == CIDR_LIMIT_SETTLE_EN_ADDR))
    begin
      limit_en_reg <= reg_wdata[CIDR_LIMIT_EN_BIT]; // [R14]
      settle_det_en_reg <= reg_wdata[CIDR_SETTLE_DET_EN_BIT]; // [R14]
    end
  end

  // Output ceiling, low byte at the lower address
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      limit_reg <= CIDR_LIMIT_RST;
    else if (clk_en)
    begin
      if (reg_wr_en && (reg_addr == CIDR_LIMIT_LOW_ADDR))
        limit_reg[7:0] <= reg_wdata; // [R13]
      if (reg_wr_en && (reg_addr == CIDR_LIMIT_HIGH_ADDR))
        limit_reg[15:8] <= reg_wdata; // [R13]
    end
  end

  // Holdover settle goal, low byte at the lower address
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      settle_reg <= CIDR_SETTLE_RST;
    else if (clk_en)
    begin
      if (reg_wr_en && (reg_addr == CIDR_SETTLE_LOW_ADDR))
        settle_reg[7:0] <= reg_wdata; // [R13]
      if (reg_wr_en && (reg_addr == CIDR_SETTLE_HIGH_ADDR))
        settle_reg[15:8] <= reg_wdata; // [R13]
    end
  end

  // Reference source and control pin level
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_src_reg <= CIDR_REF_SRC_RST;
      io_level_reg <= CIDR_IO_LEVEL_RST;
    end
    else if (clk_en)
    begin
      if (reg_wr_en && (reg_addr == CIDR_REF_SRC_ADDR))
        ref_src_reg <= reg_wdata[CIDR_REF_SRC_BIT]; // [R1]
      if (reg_wr_en && (reg_addr == CIDR_IO_LEVEL_ADDR))
        io_level_reg <= reg_wdata[CIDR_IO_LEVEL_BIT]; // [R2] [R3]
    end
  end

  // Input enables and formats written as one byte
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_en_reg <= CIDR_IN_EN_RST;
      in_fmt_reg <= CIDR_IN_FMT_RST;
      in_det_reg <= CIDR_IN_TO_DET_RST;
    end
    else if (clk_en)
    begin
      if (reg_wr_en && (reg_addr == CIDR_IN_CTRL_ADDR))
      begin
        in_en_reg <= reg_wdata[NUM_INPUTS-1:0]; // [R4] [R14]
        in_fmt_reg <= reg_wdata[CIDR_IN_FMT_LSB +: NUM_INPUTS]; // [R5] [R14]
      end
      if (reg_wr_en && (reg_addr == CIDR_IN_TO_DET_ADDR))
        in_det_reg <= reg_wdata[NUM_INPUTS-1:0];
    end
  end

  // Hysteresis shares its top byte with the CMOS thresholds
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hys_reg <= CIDR_HYS_RST;
      cmos_thr_reg <= CIDR_CMOS_THR_RST;
    end
    else if (clk_en)
    begin
      if (reg_wr_en && (reg_addr == CIDR_HYS_LOW_ADDR))
        hys_reg[7:0] <= reg_wdata; // [R13]
      if (reg_wr_en && (reg_addr == CIDR_HYS_HIGH_THR_ADDR))
      begin
        hys_reg[11:8] <= reg_wdata[CIDR_HYS_HIGH_BITS-1:0]; // [R13] [R14]
        cmos_thr_reg <= reg_wdata[CIDR_CMOS_THR_LSB +: NUM_INPUTS]; // [R7] [R14]
      end
    end
  end

  // Divider controls and reference multiplier mode
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_mult_int_reg <= CIDR_REF_MULT_INT_RST;
      half_add_reg <= CIDR_DIV_HALF_ADD_RST;
      routing_reg <= CIDR_DIV_ROUTING_RST;
      int_mode_reg <= CIDR_DIV_INT_MODE_RST;
      power_reg <= CIDR_DIV_POWER_RST;
    end
    else if (clk_en)
    begin
      if (reg_wr_en && (reg_addr == CIDR_REF_MULT_INT_ADDR))
        ref_mult_int_reg <= reg_wdata[CIDR_REF_MULT_INT_BIT];
      if (reg_wr_en && (reg_addr == CIDR_DIV_HALF_ADD_ADDR))
        half_add_reg <= reg_wdata[NUM_DIVIDERS-1:0];
      if (reg_wr_en && (reg_addr == CIDR_DIV_ROUTING_ADDR))
        routing_reg <= reg_wdata[NUM_DIVIDERS-1:0]; // [R12]
      if (reg_wr_en && (reg_addr == CIDR_DIV_INT_MODE_ADDR))
        int_mode_reg <= reg_wdata[NUM_DIVIDERS-1:0]; // [R8]
      if (reg_wr_en && (reg_addr == CIDR_DIV_POWER_ADDR))
        power_reg <= reg_wdata[NUM_DIVIDERS-1:0]; // [R11]
    end
  end

  // Moving to integer waits for soft reset; moving to fractional is immediate,
  // which is why a divider that may go fractional should start at zero
  always_comb
  begin
    if (soft_reset)
    begin
      int_mode_applied_next = int_mode_reg; // [R9]
    end
    else
    begin
      int_mode_applied_next = divider_integer_mode & int_mode_reg; // [R10]
    end
  end

  // Applied divider mode, power and routing to the output path
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      divider_integer_mode <= CIDR_DIV_INT_MODE_RST;
      divider_power_on <= CIDR_DIV_POWER_RST;
      divider_output_routing <= CIDR_DIV_ROUTING_RST;
      divider_half_add <= CIDR_DIV_HALF_ADD_RST;
    end
    else if (clk_en)
    begin
      divider_integer_mode <= int_mode_applied_next; // [R8] [R9]
      divider_power_on <= power_reg; // [R11]
      // A powered-down divider has no clock to route
      divider_output_routing <= routing_reg & power_reg; // [R12] [R11]
      divider_half_add <= half_add_reg;
    end
  end

  // Per-input buffer controls
  for (genvar i = 0; i < NUM_INPUTS; i++)
  begin : g_input
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        input_buffer_on[i] <= CIDR_IN_EN_RST[i];
        input_pulsed_cmos[i] <= CIDR_IN_FMT_RST[i];
        cmos_threshold_lvcmos[i] <= CIDR_CMOS_THR_RST[i];
        input_to_detector_enable[i] <= CIDR_IN_TO_DET_RST[i];
      end
      else if (clk_en)
      begin
        // Disabled inputs are fully powered down, format is don't care
        input_buffer_on[i] <= in_en_reg[i]; // [R4] [R6]
        input_pulsed_cmos[i] <= in_en_reg[i] & in_fmt_reg[i]; // [R5] [R6]
        cmos_threshold_lvcmos[i] <= in_en_reg[i] & cmos_thr_reg[i]; // [R7]
        input_to_detector_enable[i] <= in_en_reg[i] & in_det_reg[i];
      end
    end
  end

  // Remaining static configuration outputs
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reference_source_external <= CIDR_REF_SRC_RST;
      io_level_3v3 <= CIDR_IO_LEVEL_RST;
      input_hysteresis_select <= CIDR_HYS_RST;
      output_ceiling_enable <= CIDR_LIMIT_EN_RST;
      output_ceiling_value <= CIDR_LIMIT_RST;
      holdover_settle_detect_enable <= CIDR_SETTLE_DET_EN_RST;
      holdover_settle_goal <= CIDR_SETTLE_RST;
      reference_multiplier_integer_mode <= CIDR_REF_MULT_INT_RST;
    end
    else if (clk_en)
    begin
      reference_source_external <= ref_src_reg; // [R1]
      io_level_3v3 <= io_level_reg; // [R2]
      input_hysteresis_select <= hys_reg;
      output_ceiling_enable <= limit_en_reg;
      output_ceiling_value <= limit_reg;
      holdover_settle_detect_enable <= settle_det_en_reg;
      holdover_settle_goal <= settle_reg;
      reference_multiplier_integer_mode <= ref_mult_int_reg;
    end
  end

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb
  begin
    rdata_next = CIDR_UNMAPPED_RDATA;
    if (reg_addr == CIDR_LIMIT_SETTLE_EN_ADDR)
    begin
      rdata_next[CIDR_LIMIT_EN_BIT] = limit_en_reg;
      rdata_next[CIDR_SETTLE_DET_EN_BIT] = settle_det_en_reg;
    end
    else if (reg_addr == CIDR_LIMIT_LOW_ADDR)
      rdata_next = limit_reg[7:0];
    else if (reg_addr == CIDR_LIMIT_HIGH_ADDR)
      rdata_next = limit_reg[15:8];
    else if (reg_addr == CIDR_SETTLE_LOW_ADDR)
      rdata_next = settle_reg[7:0];
    else if (reg_addr == CIDR_SETTLE_HIGH_ADDR)
      rdata_next = settle_reg[15:8];
    else if (reg_addr == CIDR_REF_SRC_ADDR)
      rdata_next[CIDR_REF_SRC_BIT] = ref_src_reg;
    else if (reg_addr == CIDR_IO_LEVEL_ADDR)
      rdata_next[CIDR_IO_LEVEL_BIT] = io_level_reg;
    else if (reg_addr == CIDR_IN_CTRL_ADDR)
    begin
      rdata_next[NUM_INPUTS-1:0] = in_en_reg;
      rdata_next[CIDR_IN_FMT_LSB +: NUM_INPUTS] = in_fmt_reg;
    end
    else if (reg_addr == CIDR_IN_TO_DET_ADDR)
      rdata_next[NUM_INPUTS-1:0] = in_det_reg;
    else if (reg_addr == CIDR_HYS_LOW_ADDR)
      rdata_next = hys_reg[7:0];
    else if (reg_addr == CIDR_HYS_HIGH_THR_ADDR)
    begin
      rdata_next[CIDR_HYS_HIGH_BITS-1:0] = hys_reg[11:8];
      rdata_next[CIDR_CMOS_THR_LSB +: NUM_INPUTS] = cmos_thr_reg;
    end
    else if (reg_addr == CIDR_REF_MULT_INT_ADDR)
      rdata_next[CIDR_REF_MULT_INT_BIT] = ref_mult_int_reg;
    else if (reg_addr == CIDR_DIV_HALF_ADD_ADDR)
      rdata_next[NUM_DIVIDERS-1:0] = half_add_reg;
    else if (reg_addr == CIDR_DIV_ROUTING_ADDR)
      rdata_next[NUM_DIVIDERS-1:0] = routing_reg;
    else if (reg_addr == CIDR_DIV_INT_MODE_ADDR)
    begin
      // Shows the written value, not the one applied to the dividers
      rdata_next[NUM_DIVIDERS-1:0] = int_mode_reg;
    end
    else if (reg_addr == CIDR_DIV_POWER_ADDR)
      rdata_next[NUM_DIVIDERS-1:0] = power_reg;
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= CIDR_UNMAPPED_RDATA;
      reg_rd_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en)
      begin
        reg_rdata <= rdata_next;
      end
    end
  end

endmodule

`default_nettype wire

// ===== hdl/cidr_pkg.sv
// Package with register map, field layout and reset values of the clock config bank
`default_nettype none
package cidr_pkg;

  // Register byte addresses (page in the upper byte)
  localparam logic [15:0] CIDR_LIMIT_SETTLE_EN_ADDR = 16'h05ac;
  localparam logic [15:0] CIDR_LIMIT_LOW_ADDR = 16'h05ad;
  localparam logic [15:0] CIDR_LIMIT_HIGH_ADDR = 16'h05ae;
  localparam logic [15:0] CIDR_SETTLE_LOW_ADDR = 16'h05b1;
  localparam logic [15:0] CIDR_SETTLE_HIGH_ADDR = 16'h05b2;
  localparam logic [15:0] CIDR_REF_SRC_ADDR = 16'h090e;
  localparam logic [15:0] CIDR_IO_LEVEL_ADDR = 16'h0943;
  localparam logic [15:0] CIDR_IN_CTRL_ADDR = 16'h0949;
  localparam logic [15:0] CIDR_IN_TO_DET_ADDR = 16'h094a;
  localparam logic [15:0] CIDR_HYS_LOW_ADDR = 16'h094e;
  localparam logic [15:0] CIDR_HYS_HIGH_THR_ADDR = 16'h094f;
  localparam logic [15:0] CIDR_REF_MULT_INT_ADDR = 16'h095e;
  localparam logic [15:0] CIDR_DIV_HALF_ADD_ADDR = 16'h0a02;
  localparam logic [15:0] CIDR_DIV_ROUTING_ADDR = 16'h0a03;
  localparam logic [15:0] CIDR_DIV_INT_MODE_ADDR = 16'h0a04;
  localparam logic [15:0] CIDR_DIV_POWER_ADDR = 16'h0a05;

  // Counts of inputs and output dividers
  localparam int CIDR_NUM_INPUTS = 4;
  localparam int CIDR_NUM_DIVIDERS = 5;

  // Field positions inside the bytes
  localparam int CIDR_LIMIT_EN_BIT = 0;
  localparam int CIDR_SETTLE_DET_EN_BIT = 3;
  localparam int CIDR_REF_SRC_BIT = 0;
  localparam int CIDR_IO_LEVEL_BIT = 0;
  localparam int CIDR_REF_MULT_INT_BIT = 0;
  localparam int CIDR_IN_FMT_LSB = 4;
  localparam int CIDR_CMOS_THR_LSB = 4;
  localparam int CIDR_HYS_HIGH_BITS = 4;

  // Reset values of every field
  localparam logic CIDR_LIMIT_EN_RST = 1'h0;
  localparam logic CIDR_SETTLE_DET_EN_RST = 1'h0;
  localparam logic [15:0] CIDR_LIMIT_RST = 16'h0000;
  localparam logic [15:0] CIDR_SETTLE_RST = 16'h0000;
  localparam logic CIDR_REF_SRC_RST = 1'h0;
  localparam logic CIDR_IO_LEVEL_RST = 1'h0;
  localparam logic [3:0] CIDR_IN_EN_RST = 4'h0;
  localparam logic [3:0] CIDR_IN_FMT_RST = 4'h0;
  localparam logic [3:0] CIDR_IN_TO_DET_RST = 4'h0;
  localparam logic [11:0] CIDR_HYS_RST = 12'h000;
  localparam logic [3:0] CIDR_CMOS_THR_RST = 4'h0;
  localparam logic CIDR_REF_MULT_INT_RST = 1'h0;
  localparam logic [4:0] CIDR_DIV_HALF_ADD_RST = 5'h00;
  localparam logic [4:0] CIDR_DIV_ROUTING_RST = 5'h00;
  localparam logic [4:0] CIDR_DIV_INT_MODE_RST = 5'h00;
  localparam logic [4:0] CIDR_DIV_POWER_RST = 5'h00;

  // Read value of unmapped addresses and reserved bits
  localparam logic [7:0] CIDR_UNMAPPED_RDATA = 8'h00;

endpackage
`default_nettype wire

// ===== bench/cidr_config_regs_checker.sv
// Port-level assertions for the clock config register bank
`timescale 1ns/1ps
`default_nettype none
module cidr_regs_checker
  import cidr_pkg::*;
#(
  parameter int NUM_INPUTS = 4,
  parameter int NUM_DIVIDERS = 5
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  input wire logic soft_reset,
  input wire logic reg_rd_valid,
  input wire logic reference_source_external,
  input wire logic io_level_3v3,
  input wire logic [NUM_INPUTS-1:0] input_buffer_on,
  input wire logic [NUM_INPUTS-1:0] input_pulsed_cmos,
  input wire logic [NUM_INPUTS-1:0] cmos_threshold_lvcmos,
  input wire logic [NUM_INPUTS-1:0] input_to_detector_enable,
  input wire logic [15:0] output_ceiling_value,
  input wire logic [15:0] holdover_settle_goal,
  input wire logic [NUM_DIVIDERS-1:0] divider_integer_mode,
  input wire logic [NUM_DIVIDERS-1:0] divider_power_on,
  input wire logic [NUM_DIVIDERS-1:0] divider_output_routing
);
  logic wr_go;

  // Write accepted only on an enabled edge
  assign wr_go = clk_en && reg_wr_en;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Outputs land one enabled edge after storage, hence the ##1 clk_en
  chk_read_latency: assert property (clk_en && reg_rd_en |=> reg_rd_valid)
    else $error("read answer missing one cycle after request");
  chk_ref_source: assert property (
    wr_go && reg_addr == CIDR_REF_SRC_ADDR ##1 clk_en
    |=> reference_source_external == $past(reg_wdata[0], 2))
    else $error("reference source output does not follow its write");
  chk_io_level: assert property (
    wr_go && reg_addr == CIDR_IO_LEVEL_ADDR ##1 clk_en |=> io_level_3v3 == $past(reg_wdata[0], 2))
    else $error("io level output does not follow its write");
  chk_input_ctrl: assert property (
    wr_go && reg_addr == CIDR_IN_CTRL_ADDR ##1 clk_en
    |=> input_buffer_on == $past(reg_wdata[3:0], 2)
    && input_pulsed_cmos == ($past(reg_wdata[7:4], 2) & $past(reg_wdata[3:0], 2)))
    else $error("input enable or format output wrong");
  chk_input_gating: assert property (
    ((input_pulsed_cmos | cmos_threshold_lvcmos | input_to_detector_enable)
    & ~input_buffer_on) == '0)
    else $error("disabled input still shows active settings");
  chk_ceiling_low: assert property (
    wr_go && reg_addr == CIDR_LIMIT_LOW_ADDR ##1 clk_en
    |=> output_ceiling_value[7:0] == $past(reg_wdata, 2))
    else $error("ceiling low byte not in bits 7:0");
  chk_settle_high: assert property (
    wr_go && reg_addr == CIDR_SETTLE_HIGH_ADDR ##1 clk_en
    |=> holdover_settle_goal[15:8] == $past(reg_wdata, 2))
    else $error("settle goal high byte not in bits 15:8");
  chk_power_follow: assert property (
    wr_go && reg_addr == CIDR_DIV_POWER_ADDR ##1 clk_en
    |=> divider_power_on == $past(reg_wdata[4:0], 2))
    else $error("divider power output does not follow its write");
  chk_routing_gate: assert property ((divider_output_routing & ~divider_power_on) == '0)
    else $error("routing shown for a powered down divider");
  chk_mode_needs_reset: assert property (
    clk_en && !soft_reset && !$past(soft_reset)
    |=> (divider_integer_mode & ~$past(divider_integer_mode)) == '0)
    else $error("divider went integer without soft reset");
  chk_mode_clear: assert property (
    wr_go && reg_addr == CIDR_DIV_INT_MODE_ADDR && reg_wdata[4:0] == 5'h00 ##1 clk_en
    |=> divider_integer_mode == '0)
    else $error("divider did not go fractional at once");
endmodule

bind cidr_config_regs cidr_regs_checker #(.NUM_INPUTS(NUM_INPUTS), .NUM_DIVIDERS(NUM_DIVIDERS))
  i_cidr_regs_checker (.ref_clk, .arst_n, .clk_en, .reg_addr, .reg_wr_en, .reg_wdata,
  .reg_rd_en, .soft_reset, .reg_rd_valid, .reference_source_external, .io_level_3v3,
  .input_buffer_on, .input_pulsed_cmos, .cmos_threshold_lvcmos, .input_to_detector_enable,
  .output_ceiling_value, .holdover_settle_goal, .divider_integer_mode, .divider_power_on,
  .divider_output_routing);
`default_nettype wire

// ===== bench/test_clock_input_divider_config_regs.sv
// Self-checking bench for the clock config register bank
`timescale 1ns/1ps
`default_nettype none
module test_clock_input_divider_config_regs;
  import cidr_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd_en = 1'b0;
  logic soft_reset = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rd_valid, reference_source_external, io_level_3v3, output_ceiling_enable;
  logic holdover_settle_detect_enable, reference_multiplier_integer_mode;
  logic [3:0] input_buffer_on, input_pulsed_cmos, cmos_threshold_lvcmos, input_to_detector_enable;
  logic [11:0] input_hysteresis_select;
  logic [15:0] output_ceiling_value, holdover_settle_goal;
  logic [4:0] divider_half_add, divider_integer_mode, divider_power_on, divider_output_routing;
  int error_cnt = 0;
  int total_checks = 0;
  // Every mapped byte plus one unmapped address at the end
  logic [15:0] map_addr [17] = '{16'h05ac, 16'h05ad, 16'h05ae, 16'h05b1, 16'h05b2, 16'h090e,
    16'h0943, 16'h0949, 16'h094a, 16'h094e, 16'h094f, 16'h095e, 16'h0a02, 16'h0a03, 16'h0a04,
    16'h0a05, 16'h0a06};

  cidr_config_regs i_cidr_config_regs (.ref_clk, .arst_n, .clk_en, .reg_addr, .reg_wr_en,
    .reg_wdata, .reg_rd_en, .soft_reset, .reg_rdata, .reg_rd_valid, .reference_source_external,
    .io_level_3v3, .input_buffer_on, .input_pulsed_cmos, .cmos_threshold_lvcmos,
    .input_to_detector_enable, .input_hysteresis_select, .output_ceiling_enable,
    .output_ceiling_value, .holdover_settle_detect_enable, .holdover_settle_goal,
    .reference_multiplier_integer_mode, .divider_half_add, .divider_integer_mode,
    .divider_power_on, .divider_output_routing);

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Ends one idle edge later, so outputs have settled and strobes never re-raise at once
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge ref_clk);
    #1 reg_wr_en = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  // Both halves back to back, low byte first
  task automatic wr16(input logic [15:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d[7:0];
    reg_wr_en = 1'b1;
    @(posedge ref_clk);
    #1 reg_addr = a + 16'h0001;
    reg_wdata = d[15:8];
    @(posedge ref_clk);
    #1 reg_wr_en = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  // Read has a fixed latency of one edge
  task automatic rchk(input string name, input logic [15:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge ref_clk);
    #1 reg_rd_en = 1'b0;
    chk({name, " valid"}, 16'h0001, {15'h0000, reg_rd_valid});
    chk(name, {8'h00, exp}, {8'h00, reg_rdata});
    @(posedge ref_clk);
    #1;
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1 arst_n = 1'b1;
  endtask

  task automatic t_reset();
    foreach (map_addr[i])
      rchk("reset read", map_addr[i], 8'h00);
    chk("reset outputs", 16'h0000, {15'h0000, |{reference_source_external, io_level_3v3,
      input_buffer_on, input_pulsed_cmos, cmos_threshold_lvcmos, input_to_detector_enable,
      input_hysteresis_select, output_ceiling_enable, output_ceiling_value,
      holdover_settle_detect_enable, holdover_settle_goal, reference_multiplier_integer_mode,
      divider_half_add, divider_integer_mode, divider_power_on, divider_output_routing}});
    $display("test reset values done");
  endtask

  // Reserved bits are set on purpose and must read back 0
  task automatic t_ref_io();
    for (int v = 0; v < 2; v++)
    begin
      wr(CIDR_REF_SRC_ADDR, {7'h7f, v[0]});
      wr(CIDR_IO_LEVEL_ADDR, {7'h7f, v[0]});
      chk("ref source", 16'(v), {15'h0000, reference_source_external});
      chk("io level", 16'(v), {15'h0000, io_level_3v3});
      rchk("io level read", CIDR_IO_LEVEL_ADDR, {7'h00, v[0]});
    end
    $display("test reference and io level done");
  endtask

  task automatic t_inputs();
    wr(CIDR_IN_TO_DET_ADDR, 8'h0f);
    wr(CIDR_HYS_HIGH_THR_ADDR, 8'hf5);
    for (int n = 0; n < 4; n++)
    begin
      wr(CIDR_IN_CTRL_ADDR, 8'h11 << n);
      chk("buffer on", 16'h0001 << n, {12'h000, input_buffer_on});
      chk("pulsed cmos", 16'h0001 << n, {12'h000, input_pulsed_cmos});
      chk("lvcmos", 16'h0001 << n, {12'h000, cmos_threshold_lvcmos});
      chk("to detector", 16'h0001 << n, {12'h000, input_to_detector_enable});
    end
    wr(CIDR_IN_CTRL_ADDR, 8'hf0);
    chk("disabled", 16'h0000, {12'h000, input_buffer_on | input_pulsed_cmos});
    wr(CIDR_IN_CTRL_ADDR, 8'h0f);
    chk("standard format", 16'h0000, {12'h000, input_pulsed_cmos});
    wr(CIDR_HYS_LOW_ADDR, 8'h3c);
    chk("hysteresis", 16'h053c, {4'h0, input_hysteresis_select});
    wr(CIDR_HYS_HIGH_THR_ADDR, 8'h0a);
    chk("hysteresis new", 16'h0a3c, {4'h0, input_hysteresis_select});
    chk("pulsed buffer mode", 16'h0000, {12'h000, cmos_threshold_lvcmos});
    rchk("threshold read", CIDR_HYS_HIGH_THR_ADDR, 8'h0a);
    $display("test input control done");
  endtask

  task automatic t_split();
    wr16(CIDR_LIMIT_LOW_ADDR, 16'hbeef);
    wr16(CIDR_SETTLE_LOW_ADDR, 16'h1234);
    wr(CIDR_LIMIT_SETTLE_EN_ADDR, 8'h09);
    chk("ceiling", 16'hbeef, output_ceiling_value);
    chk("settle goal", 16'h1234, holdover_settle_goal);
    chk("enables", 16'h0003, {14'h0000, holdover_settle_detect_enable, output_ceiling_enable});
    wr(CIDR_LIMIT_SETTLE_EN_ADDR, 8'h08);
    chk("enables", 16'h0002, {14'h0000, holdover_settle_detect_enable, output_ceiling_enable});
    wr(CIDR_LIMIT_LOW_ADDR, 8'h00);
    chk("ceiling low only", 16'hbe00, output_ceiling_value);
    rchk("ceiling high read", CIDR_LIMIT_HIGH_ADDR, 8'hbe);
    $display("test split fields done");
  endtask

  task automatic t_dividers();
    wr(CIDR_DIV_ROUTING_ADDR, 8'h1f);
    chk("routing unpowered", 16'h0000, {11'h000, divider_output_routing});
    wr(CIDR_DIV_POWER_ADDR, 8'hff);
    chk("power", 16'h001f, {11'h000, divider_power_on});
    chk("routing", 16'h001f, {11'h000, divider_output_routing});
    wr(CIDR_DIV_POWER_ADDR, 8'h0a);
    chk("routing partial", 16'h000a, {11'h000, divider_output_routing});
    rchk("power read", CIDR_DIV_POWER_ADDR, 8'h0a);
    wr(CIDR_DIV_HALF_ADD_ADDR, 8'h15);
    wr(CIDR_REF_MULT_INT_ADDR, 8'h01);
    chk("half add", 16'h0015, {11'h000, divider_half_add});
    chk("ref mult", 16'h0001, {15'h0000, reference_multiplier_integer_mode});
    $display("test divider power and routing done");
  endtask

  // Integer mode waits for soft reset; going fractional does not
  task automatic t_int_mode();
    wr(CIDR_DIV_INT_MODE_ADDR, 8'h15);
    repeat (3) @(posedge ref_clk);
    #1 chk("mode held", 16'h0000, {11'h000, divider_integer_mode});
    rchk("mode read", CIDR_DIV_INT_MODE_ADDR, 8'h15);
    soft_reset = 1'b1;
    @(posedge ref_clk);
    #1 soft_reset = 1'b0;
    chk("mode applied", 16'h0015, {11'h000, divider_integer_mode});
    wr(CIDR_DIV_INT_MODE_ADDR, 8'h04);
    chk("mode fractional", 16'h0004, {11'h000, divider_integer_mode});
    wr(CIDR_DIV_INT_MODE_ADDR, 8'he0);
    chk("mode all fractional", 16'h0000, {11'h000, divider_integer_mode});
    $display("test divider mode done");
  endtask

  // Strobe with clock enable low, then a write to an unmapped place
  task automatic t_gate();
    clk_en = 1'b0;
    wr(CIDR_REF_SRC_ADDR, 8'h00);
    clk_en = 1'b1;
    chk("frozen", 16'h0001, {15'h0000, reference_source_external});
    rchk("frozen read", CIDR_REF_SRC_ADDR, 8'h01);
    wr(16'h0a06, 8'hff);
    rchk("unmapped", 16'h0a06, 8'h00);
    $display("test clock enable done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("timeout");
    test_done();
  end

  // Main sequence, with a second reset and reset check at the end
  initial
  begin
    do_reset();
    t_reset();
    t_ref_io();
    t_inputs();
    t_split();
    t_dividers();
    t_int_mode();
    t_gate();
    do_reset();
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire
